/* File: core/prescaled_reload_timer_consts.vh */
// constants for the prescaled reload timer
// assumes 8-bit registers, one per aligned apb word
`ifndef PRESCALED_RELOAD_TIMER_CONSTS_VH
`define PRESCALED_RELOAD_TIMER_CONSTS_VH
// register indices, byte address is four times
`define IDX_IRQ_STATUS   6'h04
`define IDX_IRQ_MASK     6'h05
`define IDX_CONTROL      6'h0c
`define IDX_STATUS       6'h0d
`define IDX_DEMOD        6'h19
`define IDX_MODE         6'h2a
`define IDX_PRESCALE     6'h2b
`define IDX_RELOAD_HI    6'h2c
`define IDX_RELOAD_LO    6'h2d
`define IDX_COUNT_HI     6'h2e
`define IDX_COUNT_LO     6'h2f
// field positions
`define BIT_TIMER_IRQ    0
`define BIT_HALT         7
`define BIT_START        6
`define BIT_RUNNING      0
`define BIT_EVEN_DIV     4
`define BIT_MULTI_FRAME  3
`define BIT_AUTO_START   7
`define GATE_HI          6
`define GATE_LO          5
`define BIT_AUTO_RELOAD  4
`define DIV_HI_HI        3
`define DIV_HI_LO        0
// gate source codes
`define GATE_NONE        2'b00
`define GATE_MULTIFUNCTION_INPUT_PIN        2'b01
`define GATE_AUX         2'b10
// reset values
`define RST_BYTE         8'h00
`define RST_COUNT        16'h0000
// timing: reference and system clock in khz
`define REF_KHZ          64'd13560
`define CLK_KHZ          64'd250000
`define ACC_BITS         24
`endif

/* File: core/prescaled_reload_timer.v */
// prescaled 16-bit reload down-counter with apb register access
// assumes mclk_in at 250 mhz, protocol strobes on mclk_in domain,
// gate pins asynchronous
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "prescaled_reload_timer_consts.vh"

// Functional notes
// R1: divider value is high nibble above low byte, 12 bits.
// R2: even select clear: tick rate is 13.56 mhz over 2p+1.
// R3: even select set: tick rate is 13.56 mhz over 2p+2.
// R4: even select resets to zero, odd formula by default.
// R5: reload value is two writable bytes, both reset to zero.
// R6: every start event loads the counter from the reload value.
// R7: reload writes while running take effect at next start or next auto reload.
// R8: counter value readable as two read-only bytes.
// R9: auto start at transmit end; stop at 5th bit unless multi-frame.
// R10: auto reload set: reload and keep counting instead of stopping.
// R11: auto reload clear: count to zero then raise timer flag.
// R12: gate field 00 none, 01 multifunction pin, 10 auxiliary pin.
// R13: count decrements once per prescaler tick while running and gated.
module prescaled_reload_timer (
   input  wire        mclk_in,
   input  wire        rst_in,
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [7:0]  paddr_in,
   input  wire [31:0] pwdata_in,
   output reg  [31:0] prdata_out,
   output wire        pready_out,
   output wire        pslverr_out,
   input  wire        tx_end_in,
   input  wire        rx_fifth_bit_in,
   input  wire        multifunction_input_pin_in,
   input  wire        auxiliary_pin_one_in,
   output wire        irq_out
);

   localparam [63:0] ACC_INC_W =
      (`REF_KHZ << `ACC_BITS) / `CLK_KHZ;
   localparam [`ACC_BITS-1:0] ACC_INC = ACC_INC_W[`ACC_BITS-1:0];

   function [5:0] word_index;
      input [7:0] addr;
      begin
         word_index = addr[7:2];
      end
   endfunction

   function mapped;
      input [7:0] addr;
      reg   [5:0] idx;
      begin
         idx = addr[7:2];
         mapped = (addr[1:0] == 2'b00) &&
                  (idx == `IDX_IRQ_STATUS || idx == `IDX_IRQ_MASK ||
                   idx == `IDX_CONTROL || idx == `IDX_STATUS ||
                   idx == `IDX_DEMOD || idx == `IDX_MODE ||
                   idx == `IDX_PRESCALE || idx == `IDX_RELOAD_HI ||
                   idx == `IDX_RELOAD_LO || idx == `IDX_COUNT_HI ||
                   idx == `IDX_COUNT_LO);
      end
   endfunction

   // register state
   reg [7:0]  mode_q;
   reg [7:0]  divider_low_byte_q;
   reg [7:0]  demod_q;
   reg [7:0]  reload_upper_byte_q;
   reg [7:0]  reload_lower_byte_q;
   reg        irq_status_q;
   reg        irq_mask_q;
   reg [15:0] count_q;
   reg [15:0] count_d;
   reg        running_q;
   reg        running_d;
   reg [`ACC_BITS-1:0] acc_q;
   reg        ref_tick_q;
   reg [12:0] pre_q;
   reg        tick_q;
   reg [1:0]  multifunction_input_pin_sync_q;
   reg [1:0]  aux_sync_q;

   wire [5:0]  idx;
   wire        setup_ph;
   wire        access_ph;
   wire        wr;
   wire        ok;
   wire [7:0]  wbyte;
   wire        protocol_auto_start;
   wire [1:0]  gate_source_select;
   wire        auto_reload_enable;
   wire [3:0]  divider_high_nibble;
   wire [11:0] divider_value;
   wire        even_division_select;
   wire        multi_frame_receive;
   wire [12:0] divisor_last;
   wire [`ACC_BITS:0] acc_sum;
   wire        sw_start;
   wire        immediate_halt;
   wire        start_evt;
   wire        stop_evt;
   wire        gate_open;
   wire        timer_interrupt_flag;
   wire        irq_clr;

   assign idx       = word_index(paddr_in);
   assign setup_ph  = psel_in & ~penable_in;
   assign access_ph = psel_in & penable_in;
   assign ok        = mapped(paddr_in);
   assign wr        = access_ph & pwrite_in & ok;
   assign wbyte     = pwdata_in[7:0];

   // zero wait state slave, error on unmapped address
   assign pready_out  = 1'b1;
   assign pslverr_out = access_ph & ~ok;

   // mode and demod fields
   assign protocol_auto_start = mode_q[`BIT_AUTO_START];
   assign gate_source_select  = mode_q[`GATE_HI:`GATE_LO];
   assign auto_reload_enable  = mode_q[`BIT_AUTO_RELOAD];
   assign divider_high_nibble = mode_q[`DIV_HI_HI:`DIV_HI_LO];
   assign even_division_select = demod_q[`BIT_EVEN_DIV];
   assign multi_frame_receive  = demod_q[`BIT_MULTI_FRAME];

   assign divider_value = {divider_high_nibble,
                           divider_low_byte_q};  // [R1]
   // last count of reference divider: 2p or 2p+1
   assign divisor_last = even_division_select ?
      {divider_value, 1'b1} :  // [R3]
      {divider_value, 1'b0};   // [R2]

   // control register write strobes
   assign sw_start = wr & (idx == `IDX_CONTROL) &
                     wbyte[`BIT_START];
   assign immediate_halt = wr & (idx == `IDX_CONTROL) &
                           wbyte[`BIT_HALT];
   assign start_evt = sw_start |
                      (protocol_auto_start & tx_end_in);  // [R9]
   assign stop_evt  = immediate_halt |
      (protocol_auto_start & ~multi_frame_receive &
       rx_fifth_bit_in);  // [R9]

   // gate source selection
   assign gate_open =
      (gate_source_select == `GATE_MULTIFUNCTION_INPUT_PIN) ? multifunction_input_pin_sync_q[1] :
      (gate_source_select == `GATE_AUX)  ? aux_sync_q[1] :
      1'b1;  // [R12]

   assign acc_sum = {1'b0, acc_q} + {1'b0, ACC_INC};

   // gate pin synchronisers
   always @(posedge mclk_in) begin
      if (rst_in) begin
         multifunction_input_pin_sync_q <= 2'b00;
         aux_sync_q  <= 2'b00;
      end else begin
         multifunction_input_pin_sync_q <= {multifunction_input_pin_sync_q[0], multifunction_input_pin_in};
         aux_sync_q  <= {aux_sync_q[0], auxiliary_pin_one_in};
      end
   end

   // 13.56 mhz reference from fractional accumulator
   always @(posedge mclk_in) begin
      if (rst_in) begin
         acc_q      <= {`ACC_BITS{1'b0}};
         ref_tick_q <= 1'b0;
      end else begin
         acc_q      <= acc_sum[`ACC_BITS-1:0];
         ref_tick_q <= acc_sum[`ACC_BITS];
      end
   end

   // prescaler, restarts with each start event
   always @(posedge mclk_in) begin
      if (rst_in) begin
         pre_q  <= 13'h0000;
         tick_q <= 1'b0;
      end else if (start_evt) begin
         pre_q  <= 13'h0000;
         tick_q <= 1'b0;
      end else if (ref_tick_q) begin
         if (pre_q >= divisor_last) begin
            pre_q  <= 13'h0000;
            tick_q <= 1'b1;  // [R2] [R3]
         end else begin
            pre_q  <= pre_q + 13'h0001;
            tick_q <= 1'b0;
         end
      end else begin
         tick_q <= 1'b0;
      end
   end

   // down-counter next state
   assign timer_interrupt_flag = running_q & tick_q & gate_open &
      (count_q <= 16'h0001) & ~auto_reload_enable & ~start_evt &
      ~stop_evt;
   always @* begin
      count_d   = count_q;
      running_d = running_q;
      if (start_evt) begin
         count_d   = {reload_upper_byte_q,
                      reload_lower_byte_q};  // [R6] [R7]
         running_d = 1'b1;
      end else if (stop_evt) begin
         running_d = 1'b0;  // [R9]
      end else if (running_q & tick_q & gate_open) begin  // [R13]
         if (count_q <= 16'h0001) begin
            if (auto_reload_enable) begin
               count_d = {reload_upper_byte_q,
                          reload_lower_byte_q};  // [R10]
            end else begin
               count_d   = 16'h0000;  // [R11]
               running_d = 1'b0;
            end
         end else begin
            count_d = count_q - 16'h0001;  // [R13]
         end
      end
   end

   always @(posedge mclk_in) begin
      if (rst_in) begin
         count_q   <= `RST_COUNT;
         running_q <= 1'b0;
      end else begin
         count_q   <= count_d;
         running_q <= running_d;
      end
   end

   // writable registers
   always @(posedge mclk_in) begin
      if (rst_in) begin
         mode_q              <= `RST_BYTE;
         divider_low_byte_q  <= `RST_BYTE;
         demod_q             <= `RST_BYTE;  // [R4]
         reload_upper_byte_q <= `RST_BYTE;  // [R5]
         reload_lower_byte_q <= `RST_BYTE;  // [R5]
         irq_mask_q          <= 1'b0;
      end else if (wr) begin
         case (idx)
            `IDX_MODE:      mode_q <= wbyte;
            `IDX_PRESCALE:  divider_low_byte_q <= wbyte;
            `IDX_DEMOD:     demod_q <= wbyte;
            `IDX_RELOAD_HI: reload_upper_byte_q <= wbyte;  // [R5]
            `IDX_RELOAD_LO: reload_lower_byte_q <= wbyte;  // [R5]
            `IDX_IRQ_MASK:  irq_mask_q <= wbyte[`BIT_TIMER_IRQ];
            default: ;
         endcase
      end
   end

   // sticky timer flag, write one clears, event wins
   assign irq_clr = wr & (idx == `IDX_IRQ_STATUS) &
                    wbyte[`BIT_TIMER_IRQ];
   always @(posedge mclk_in) begin
      if (rst_in) begin
         irq_status_q <= 1'b0;
      end else if (timer_interrupt_flag) begin
         irq_status_q <= 1'b1;  // [R11]
      end else if (irq_clr) begin
         irq_status_q <= 1'b0;
      end
   end

   assign irq_out = irq_status_q & irq_mask_q;

   // read data captured in the setup phase
   always @(posedge mclk_in) begin
      if (rst_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (setup_ph) begin
         prdata_out <= 32'h0000_0000;
         if (!pwrite_in && paddr_in[1:0] == 2'b00) begin
            case (idx)
               `IDX_IRQ_STATUS: prdata_out[0] <= irq_status_q;
               `IDX_IRQ_MASK:   prdata_out[0] <= irq_mask_q;
               `IDX_STATUS:     prdata_out[0] <= running_q;
               `IDX_DEMOD:      prdata_out[7:0] <= demod_q;
               `IDX_MODE:       prdata_out[7:0] <= mode_q;
               `IDX_PRESCALE:
                  prdata_out[7:0] <= divider_low_byte_q;
               `IDX_RELOAD_HI:
                  prdata_out[7:0] <= reload_upper_byte_q;
               `IDX_RELOAD_LO:
                  prdata_out[7:0] <= reload_lower_byte_q;
               `IDX_COUNT_HI:
                  prdata_out[7:0] <= count_q[15:8];  // [R8]
               `IDX_COUNT_LO:
                  prdata_out[7:0] <= count_q[7:0];   // [R8]
               default: prdata_out <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule // prescaled_reload_timer
`default_nettype wire

/* File: sim/prt_checker.sv */
// port checker for prescaled_reload_timer
// assumes bind to the design top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module prt_checker (
   input wire logic        mclk_in,
   input wire logic        rst_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic        irq_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   wire acc = psel_in && penable_in;
   wire setup = psel_in && !penable_in;
   property p_rdy; acc |-> pready_out; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready");
   property p_hi; prdata_out[31:8] == 24'h00_0000; endproperty
   a_hi: assert property (p_hi) else $error("upper data");
   property p_eph; pslverr_out |-> acc; endproperty
   a_eph: assert property (p_eph) else $error("stray error");
   property p_mis; acc && paddr_in[1:0] != 2'b00 |-> pslverr_out; endproperty
   a_mis: assert property (p_mis) else $error("no error");
   property p_map; acc && paddr_in == 8'hb8 |-> !pslverr_out; endproperty
   a_map: assert property (p_map) else $error("count unmapped");
   property p_ctl;
      setup && !pwrite_in && paddr_in == 8'h30 |=> prdata_out == 32'h0;
   endproperty
   a_ctl: assert property (p_ctl) else $error("control read");
   property p_hold; !setup |=> $stable(prdata_out); endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_irqf;
      $fell(irq_out) |-> $past(acc && pwrite_in) || $past(rst_in);
   endproperty
   a_irqf: assert property (p_irqf) else $error("irq fell");
   c_err: cover property (acc && pslverr_out);
   c_irq: cover property ($rose(irq_out));
   c_clr: cover property ($fell(irq_out));
endmodule // prt_checker
bind prescaled_reload_timer prt_checker prt_checker_inst (.mclk_in,
   .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out,
   .pready_out, .pslverr_out, .irq_out);
`default_nettype wire

/* File: sim/prescaled_reload_timer_tb.sv */
// self-checking bench for prescaled_reload_timer
// assumes the consts header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "prescaled_reload_timer_consts.vh"
module prescaled_reload_timer_tb;
   logic        mclk_in = 0, rst_in = 1, psel = 0, pen = 0, pwr = 0;
   logic [7:0]  pa = 0;
   logic [31:0] pwd = 0, prd, r;
   logic        prdy, err, irq, se, tx = 0, rx5 = 0, multifunction_input_pin = 0, aux = 0;
   logic [7:0]  mdl [64];
   int          mismatches = 0, tests_run = 0, c, c2;
   prescaled_reload_timer prescaled_reload_timer_inst (.mclk_in(mclk_in),
      .rst_in(rst_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
      .pslverr_out(err), .tx_end_in(tx), .rx_fifth_bit_in(rx5),
      .multifunction_input_pin_in(multifunction_input_pin), .auxiliary_pin_one_in(aux),
      .irq_out(irq));
   task finish_test;
      if (mismatches == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      pa <= a;
      pwd <= {24'h00_0000, d};
      @(posedge mclk_in);
      pen <= 1;
      @(posedge mclk_in);
      while (prdy !== 1'b1) @(posedge mclk_in);
      r = prd;
      se = err;
      psel <= 0;
      pen <= 0;
   endtask
   task wr(input logic [5:0] i, input logic [7:0] d);
      apb(1, {i, 2'b00}, d);
      mdl[i] = d;
   endtask
   task rd(input logic [5:0] i);
      apb(0, {i, 2'b00}, 8'h00);
   endtask
   task cnt;
      rd(`IDX_COUNT_HI);
      c = r[7:0] << 8;
      rd(`IDX_COUNT_LO);
      c = c | r[7:0];
   endtask
   task ld(input logic [7:0] hi, input logic [7:0] lo);
      wr(`IDX_RELOAD_HI, hi);
      wr(`IDX_RELOAD_LO, lo);
   endtask
   task pulse(input bit s);
      @(posedge mclk_in);
      if (s) rx5 <= 1;
      else tx <= 1;
      @(posedge mclk_in);
      tx <= 0;
      rx5 <= 0;
   endtask
   task rate(input logic [11:0] p, input bit ev, input int w);
      int n;
      wr(`IDX_DEMOD, {3'b000, ev, 4'h0});
      wr(`IDX_MODE, {4'h0, p[11:8]});
      wr(`IDX_PRESCALE, p[7:0]);
      ld(8'h03, 8'he8);
      wr(`IDX_CONTROL, 8'h40);
      cnt;
      chk(c, 1000);
      ld(8'h00, 8'h05);
      cyc(w);
      wr(`IDX_CONTROL, 8'h80);
      cnt;
      n = 1000 - (w + 21) * 13560 / (250000 * (2 * p + 1 + ev));
      chk(c >= n - 1 && c <= n + 1, 1);
      rd(`IDX_STATUS);
      chk(r, 0);
      wr(`IDX_CONTROL, 8'h40);
      cnt;
      chk(c, 5);
      rd(`IDX_STATUS);
      chk(r, 1);
   endtask
   initial forever #2 mclk_in = ~mclk_in;
   initial begin
      cyc(90000);
      mismatches++;
      finish_test;
   end
   initial begin
      c = $urandom(20);
      foreach (mdl[k]) mdl[k] = 8'h00;
      cyc(10);
      rst_in <= 0;
      rd(`IDX_DEMOD);
      chk(r, 0);
      rd(`IDX_CONTROL);
      chk(r, 0);
      for (int k = 0; k < 8; k++) begin
         rd(k[0] ? `IDX_RELOAD_LO : `IDX_RELOAD_HI);
         chk(r, mdl[k[0] ? `IDX_RELOAD_LO : `IDX_RELOAD_HI]);
         ld(8'($urandom), 8'($urandom));
      end
      apb(0, 8'hfc, 8'h00);
      chk(se, 1);
      chk(r, 0);
      apb(1, 8'hb9, 8'h00);
      chk(se, 1);
      wr(`IDX_COUNT_HI, 8'haa);
      cnt;
      chk(c, 0);
      rate(12'h003, 0, 4000);
      rate(12'h003, 1, 4000);
      rate(12'h100, 0, 20000);
      wr(`IDX_IRQ_MASK, 8'h01);
      wr(`IDX_MODE, 8'h00);
      wr(`IDX_PRESCALE, 8'h03);
      ld(8'h00, 8'h03);
      wr(`IDX_CONTROL, 8'h40);
      cyc(600);
      cnt;
      chk(c, 0);
      chk(irq, 1);
      wr(`IDX_IRQ_MASK, 8'h00);
      rd(`IDX_IRQ_STATUS);
      chk(r, 1);
      chk(irq, 0);
      wr(`IDX_IRQ_MASK, 8'h01);
      wr(`IDX_IRQ_STATUS, 8'h01);
      rd(`IDX_IRQ_STATUS);
      chk(r, 0);
      chk(irq, 0);
      wr(`IDX_MODE, 8'h10);
      wr(`IDX_CONTROL, 8'h40);
      cyc(1000);
      rd(`IDX_IRQ_STATUS);
      chk(r, 0);
      wr(`IDX_CONTROL, 8'h80);
      cnt;
      chk(c >= 1 && c <= 3, 1);
      ld(8'h03, 8'he8);
      for (int g = 0; g < 4; g++) begin
         wr(`IDX_MODE, {1'b0, g[1:0], 5'h00});
         multifunction_input_pin <= (g == 2);
         aux <= (g == 1);
         wr(`IDX_CONTROL, 8'h40);
         cyc(600);
         cnt;
         chk(c < 1000, g == 0 || g == 3);
         multifunction_input_pin <= 1;
         aux <= 1;
         cyc(600);
         cnt;
         chk(c < 1000, 1);
         wr(`IDX_CONTROL, 8'h80);
      end
      for (int m = 0; m < 2; m++) begin
         wr(`IDX_DEMOD, {4'h0, m[0], 3'b000});
         wr(`IDX_MODE, 8'h80);
         pulse(0);
         cnt;
         chk(c, 1000);
         cyc(400);
         pulse(1);
         cnt;
         c2 = c;
         cyc(400);
         cnt;
         chk(c < c2, m == 1);
      end
      wr(`IDX_CONTROL, 8'h80);
      cnt;
      c2 = c;
      cyc(300);
      cnt;
      chk(c, c2);
      finish_test;
   end
endmodule // prescaled_reload_timer_tb
`default_nettype wire
